// >>> rtl/fbs_consts.svh
`ifndef FBS_CONSTS_SVH
`define FBS_CONSTS_SVH

`define FBS_CLOCK_HZ        10000000
`define FBS_TICK_US         1000
`define FBS_TICK_CYCLES     ((`FBS_CLOCK_HZ / 1000000) * `FBS_TICK_US)
`define FBS_GROUP1          2'h1
`define FBS_GROUP2          2'h2
`define FBS_DUPCHK_MSGS     2'h2
`define FBS_DUPCHK_GAP_MS   8'h0A
`define FBS_CTRL_WDOG_MS    8'h64
`define FBS_FLASH_HALF_MS   10'h1F4
`define FBS_CTRL_BITS       4
`define FBS_TIMEOUT_RST     8'h00

`endif

// >>> rtl/fbs_pkg.sv
package fbs_pkg;

  typedef enum logic [3:0] {
    MSG_NONE,
    MSG_UNCONN_OPEN_EXPL,
    MSG_UNCONN_OPEN_IO,
    MSG_UNCONN_CLOSE,
    MSG_SET_TIMEOUT,
    MSG_EXPL_READ,
    MSG_POLL,
    MSG_EXPL_RSP,
    MSG_POLL_RSP,
    MSG_DUP_CHECK
  } fbs_msg_t;

  typedef enum logic [1:0] {
    RATE_125K,
    RATE_250K,
    RATE_500K,
    RATE_INVALID
  } fbs_rate_t;

  typedef enum logic [2:0] {
    ST_START,
    ST_BAD_RATE,
    ST_DUPCHK,
    ST_ONLINE,
    ST_FAULT
  } fbs_dev_state_t;

  typedef enum logic [2:0] {
    M_IDLE,
    M_SEND,
    M_WAIT,
    M_READY,
    M_POLL_WAIT
  } fbs_mst_state_t;

endpackage

// >>> rtl/fbs_link_if.sv
`timescale 1ns/1ps
interface fbs_link_if;
  import fbs_pkg::*;
  logic             m2d_valid;
  logic [1:0]       m2d_group;
  fbs_msg_t         m2d_kind;
  logic [5:0]       m2d_dest;
  logic [7:0]       m2d_data;
  logic             d2m_valid;
  logic [1:0]       d2m_group;
  fbs_msg_t         d2m_kind;
  logic [5:0]       d2m_src;
  logic [31:0]      d2m_data;

  modport dev (
    input  m2d_valid, m2d_group, m2d_kind, m2d_dest, m2d_data,
    output d2m_valid, d2m_group, d2m_kind, d2m_src, d2m_data
  );
  modport mst (
    output m2d_valid, m2d_group, m2d_kind, m2d_dest, m2d_data,
    input  d2m_valid, d2m_group, d2m_kind, d2m_src, d2m_data
  );
endinterface

// >>> rtl/fbs_slave_node.sv
// How it works
// - address from six switches, first is lsb
// - two switches pick 125, 250, 500 kbps
// - integrator keeps every node address unique
// - slave only, group 2 except poll response
// - connections opened only by unconnected request, closed by it or I/O timeout
// - separate I/O port and explicit port
// - I/O polling usable only after timeout armed
// - missed poll drops I/O until reopened
// - watchdog supervises the protocol controller
// - configuration data carried as plain binary
// - all lamps dark while not online and not faulted
// - run lamp steady when online, allocated, no I/O timeout
// - run lamp flashes on recoverable fault
// - error lamp flashes when online, unallocated
// - error lamp steady on unrecoverable fault
// - send address check messages before online
// - one poll response for each poll command while I/O ready
// - master zeroes a control bit between repeats
`timescale 1ns/1ps
`include "fbs_consts.svh"
module fbs_slave_node
  import fbs_pkg::*;
#(
  parameter int TICK_CYCLES = `FBS_TICK_CYCLES
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [5:0]                i_address_switch,
  input  wire logic                      i_rate_select_switch_a,
  input  wire logic                      i_rate_select_switch_b,
  input  wire logic [31:0]               i_position,
  input  wire logic                      i_ctrl_alive,
  fbs_link_if.dev                        link,
  output logic      [5:0]                o_node_address,
  output fbs_rate_t                      o_bit_rate,
  output logic                           o_online,
  output logic                           o_io_ready,
  output logic      [`FBS_CTRL_BITS-1:0] o_control_bits,
  output logic                           o_control_valid,
  output logic                           o_lamp_ok,
  output logic                           o_lamp_run,
  output logic                           o_lamp_err
);

  fbs_dev_state_t state;
  logic [13:0]    tick_cnt;
  logic           tick;
  logic [7:0]     dup_gap;
  logic [1:0]     dup_sent;
  logic [7:0]     wdog_cnt;
  logic [7:0]     io_cnt;
  logic [7:0]     io_timeout;
  logic [9:0]     flash_cnt;
  logic           flash;
  logic           expl_est;
  logic           io_est;
  logic           io_armed;
  logic           io_timedout;
  logic           allocated;
  logic           req;
  logic           g2;
  logic           io_expire;
  logic           dup_conflict;
  logic           dup_send;

  function automatic fbs_rate_t rate_decode(input logic a, input logic b);
    case ({b, a})
      2'h0:    rate_decode = RATE_125K;
      2'h1:    rate_decode = RATE_250K;
      2'h2:    rate_decode = RATE_500K;
      default: rate_decode = RATE_INVALID;
    endcase
  endfunction

  // one-ms enable shared by every slow timer
  assign tick = (tick_cnt == 14'(TICK_CYCLES - 1));

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt <= 14'h0000;
    end else if (tick) begin
      tick_cnt <= 14'h0000;
    end else begin
      tick_cnt <= tick_cnt + 14'h0001;
    end
  end

  // switches are straps: caught once after reset release
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_node_address <= 6'h00;
      o_bit_rate     <= RATE_125K;
    end else if (state == ST_START) begin
      o_node_address <= i_address_switch;
      o_bit_rate     <= rate_decode(i_rate_select_switch_a,
                                    i_rate_select_switch_b);
    end
  end

  assign dup_conflict = link.m2d_valid && link.m2d_kind == MSG_DUP_CHECK &&
                        link.m2d_dest == o_node_address;
  assign dup_send     = state == ST_DUPCHK && tick && dup_gap == 8'h00 &&
                        dup_sent != `FBS_DUPCHK_MSGS;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_START;
    end else begin
      case (state)
        ST_START: begin
          if (rate_decode(i_rate_select_switch_a,
                          i_rate_select_switch_b) == RATE_INVALID) begin
            state <= ST_BAD_RATE;
          end else begin
            state <= ST_DUPCHK;
          end
        end
        ST_DUPCHK: begin
          if (dup_conflict) begin
            state <= ST_FAULT;
          end else if (tick && dup_gap == 8'h00 &&
                       dup_sent == `FBS_DUPCHK_MSGS) begin
            state <= ST_ONLINE;
          end
        end
        ST_ONLINE: begin
          if (dup_conflict || (tick && wdog_cnt == `FBS_CTRL_WDOG_MS)) begin
            state <= ST_FAULT;
          end
        end
        ST_BAD_RATE: state <= ST_BAD_RATE;
        ST_FAULT:    state <= ST_FAULT;
        default:     state <= ST_START;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      dup_gap  <= `FBS_DUPCHK_GAP_MS;
      dup_sent <= 2'h0;
    end else if (state == ST_DUPCHK && tick) begin
      if (dup_gap == 8'h00) begin
        dup_gap <= `FBS_DUPCHK_GAP_MS;
        if (dup_send) begin
          dup_sent <= dup_sent + 2'h1;
        end
      end else begin
        dup_gap <= dup_gap - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wdog_cnt <= 8'h00;
    end else if (i_ctrl_alive || state != ST_ONLINE) begin
      wdog_cnt <= 8'h00;
    end else if (tick) begin
      wdog_cnt <= wdog_cnt + 8'h01;
    end
  end

  // only group 2 requests addressed here
  assign req = link.m2d_valid && state == ST_ONLINE &&
               link.m2d_dest == o_node_address;
  assign g2  = link.m2d_group == `FBS_GROUP2;
  assign io_expire = tick && io_armed && io_cnt >= io_timeout;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      expl_est    <= 1'b0;
      io_est      <= 1'b0;
      io_armed    <= 1'b0;
      io_timedout <= 1'b0;
      io_timeout  <= `FBS_TIMEOUT_RST;
    end else if (state != ST_ONLINE) begin
      expl_est <= 1'b0;
      io_est   <= 1'b0;
      io_armed <= 1'b0;
    end else if (req && g2 && link.m2d_kind == MSG_UNCONN_OPEN_EXPL) begin
      expl_est <= 1'b1;
    end else if (req && g2 && link.m2d_kind == MSG_UNCONN_OPEN_IO) begin
      io_est      <= 1'b1;
      io_armed    <= 1'b0;
      io_timedout <= 1'b0;
    end else if (req && g2 && link.m2d_kind == MSG_UNCONN_CLOSE) begin
      expl_est <= 1'b0;
      io_est   <= 1'b0;
      io_armed <= 1'b0;
    end else if (req && g2 && link.m2d_kind == MSG_SET_TIMEOUT &&
                 expl_est && io_est && link.m2d_data != 8'h00) begin
      io_timeout <= link.m2d_data;
      io_armed   <= 1'b1;
    end else if (io_expire) begin
      io_est      <= 1'b0;
      io_armed    <= 1'b0;
      io_timedout <= 1'b1;
    end
  end

  assign o_io_ready = io_est && io_armed;
  assign o_online   = state == ST_ONLINE;
  assign allocated  = expl_est || io_est;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      io_cnt <= 8'h00;
    end else if (!io_armed ||
                 (req && g2 && link.m2d_kind == MSG_POLL)) begin
      io_cnt <= 8'h00;
    end else if (tick) begin
      io_cnt <= io_cnt + 8'h01;
    end
  end

  // two ports: poll answers and explicit answers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      link.d2m_valid  <= 1'b0;
      link.d2m_group  <= `FBS_GROUP2;
      link.d2m_kind   <= MSG_NONE;
      link.d2m_src    <= 6'h00;
      link.d2m_data   <= 32'h00000000;
      o_control_bits  <= '0;
      o_control_valid <= 1'b0;
    end else begin
      link.d2m_valid  <= 1'b0;
      o_control_valid <= 1'b0;
      link.d2m_src    <= o_node_address;
      if (dup_send) begin
        link.d2m_valid <= 1'b1;
        link.d2m_group <= `FBS_GROUP2;
        link.d2m_kind  <= MSG_DUP_CHECK;
        link.d2m_data  <= 32'h00000000;
      end else if (req && g2 && link.m2d_kind == MSG_POLL &&
                   o_io_ready) begin
        link.d2m_valid  <= 1'b1;
        link.d2m_group  <= `FBS_GROUP1;
        link.d2m_kind   <= MSG_POLL_RSP;
        link.d2m_data   <= i_position;
        o_control_bits  <= link.m2d_data[`FBS_CTRL_BITS-1:0];
        o_control_valid <= 1'b1;
      end else if (req && g2 && (link.m2d_kind == MSG_UNCONN_OPEN_EXPL ||
                   link.m2d_kind == MSG_UNCONN_OPEN_IO ||
                   link.m2d_kind == MSG_UNCONN_CLOSE ||
                   (expl_est && (link.m2d_kind == MSG_SET_TIMEOUT ||
                                 link.m2d_kind == MSG_EXPL_READ)))) begin
        link.d2m_valid <= 1'b1;
        link.d2m_group <= `FBS_GROUP2;
        link.d2m_kind  <= MSG_EXPL_RSP;
        link.d2m_data  <= {16'h0000, io_timeout, 2'(o_bit_rate),
                           o_node_address};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flash_cnt <= 10'h000;
      flash     <= 1'b0;
    end else if (tick) begin
      if (flash_cnt == `FBS_FLASH_HALF_MS - 10'h001) begin
        flash_cnt <= 10'h000;
        flash     <= !flash;
      end else begin
        flash_cnt <= flash_cnt + 10'h001;
      end
    end
  end

  // lamps registered so they never glitch
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lamp_ok  <= 1'b0;
      o_lamp_run <= 1'b0;
      o_lamp_err <= 1'b0;
    end else if (state == ST_FAULT) begin
      o_lamp_ok  <= 1'b0;
      o_lamp_run <= 1'b0;
      o_lamp_err <= 1'b1;
    end else if (state != ST_ONLINE) begin
      o_lamp_ok  <= 1'b0;
      o_lamp_run <= 1'b0;
      o_lamp_err <= 1'b0;
    end else begin
      o_lamp_ok  <= 1'b1;
      o_lamp_run <= io_timedout ? flash : allocated;
      o_lamp_err <= !allocated && flash;
    end
  end

endmodule

// >>> rtl/fbs_master.sv
`timescale 1ns/1ps
`include "fbs_consts.svh"
module fbs_master
  import fbs_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [5:0]                i_node_address,
  input  wire logic                      i_start,
  input  wire logic                      i_stop,
  input  wire logic [7:0]                i_timeout_ms,
  input  wire logic                      i_poll,
  input  wire logic [`FBS_CTRL_BITS-1:0] i_control,
  fbs_link_if.mst                        link,
  output logic                           o_ready,
  output logic      [31:0]               o_position,
  output logic                           o_position_valid
);

  fbs_mst_state_t             state;
  logic [1:0]                 step;
  logic [`FBS_CTRL_BITS-1:0]  last_ctrl;
  logic                       rsp;
  logic                       send;
  fbs_msg_t                   next_kind;
  logic [7:0]                 next_data;

  assign rsp = link.d2m_valid && link.d2m_src == i_node_address;
  assign o_ready = state == M_READY;

  // open explicit, open I/O, then arm the timeout
  always_comb begin
    next_data = 8'h00;
    case (step)
      2'h0:    next_kind = MSG_UNCONN_OPEN_EXPL;
      2'h1:    next_kind = MSG_UNCONN_OPEN_IO;
      2'h2: begin
        next_kind = MSG_SET_TIMEOUT;
        next_data = i_timeout_ms;
      end
      default: next_kind = MSG_UNCONN_CLOSE;
    endcase
  end

  assign send = state == M_SEND;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= M_IDLE;
      step  <= 2'h0;
    end else begin
      case (state)
        M_IDLE: begin
          if (i_start) begin
            step  <= 2'h0;
            state <= M_SEND;
          end
        end
        M_SEND: state <= M_WAIT;
        M_WAIT: begin
          if (rsp && link.d2m_kind == MSG_EXPL_RSP) begin
            if (step == 2'h3) begin
              state <= M_IDLE;
            end else if (step == 2'h2) begin
              state <= M_READY;
            end else begin
              step  <= step + 2'h1;
              state <= M_SEND;
            end
          end
        end
        M_READY: begin
          if (i_stop) begin
            step  <= 2'h3;
            state <= M_SEND;
          end else if (i_poll) begin
            state <= M_POLL_WAIT;
          end
        end
        M_POLL_WAIT: begin
          if (rsp && link.d2m_kind == MSG_POLL_RSP) begin
            state <= M_READY;
          end
        end
        default: state <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      link.m2d_valid   <= 1'b0;
      link.m2d_group   <= `FBS_GROUP2;
      link.m2d_kind    <= MSG_NONE;
      link.m2d_dest    <= 6'h00;
      link.m2d_data    <= 8'h00;
      last_ctrl        <= '0;
      o_position       <= 32'h00000000;
      o_position_valid <= 1'b0;
    end else begin
      link.m2d_valid   <= 1'b0;
      o_position_valid <= 1'b0;
      link.m2d_dest    <= i_node_address;
      link.m2d_group   <= `FBS_GROUP2;
      if (send) begin
        link.m2d_valid <= 1'b1;
        link.m2d_kind  <= next_kind;
        link.m2d_data  <= next_data;
      end else if (state == M_READY && !i_stop && i_poll) begin
        // a repeated bit goes out as zero first
        link.m2d_valid <= 1'b1;
        link.m2d_kind  <= MSG_POLL;
        link.m2d_data  <= {4'h0, i_control & ~last_ctrl};
        last_ctrl      <= i_control & ~last_ctrl;
      end
      if (rsp && link.d2m_kind == MSG_POLL_RSP) begin
        o_position       <= link.d2m_data;
        o_position_valid <= 1'b1;
      end
    end
  end

endmodule

// >>> tb/fbs_link_checker.sv
`timescale 1ns/1ps
module fbs_link_checker
  import fbs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        m2d_valid,
  input  wire logic [1:0]  m2d_group,
  input  wire fbs_msg_t    m2d_kind,
  input  wire logic [5:0]  m2d_dest,
  input  wire logic [7:0]  m2d_data,
  input  wire logic        d2m_valid,
  input  wire logic [1:0]  d2m_group,
  input  wire fbs_msg_t    d2m_kind,
  input  wire logic [5:0]  d2m_src,
  input  wire logic [31:0] d2m_data
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic [1:0] dup_count;
  logic       armed;
  wire        rsp = d2m_valid && d2m_kind != MSG_DUP_CHECK;
  wire        poll_rsp = d2m_valid && d2m_kind == MSG_POLL_RSP;

  // saturates so a third check still shows up
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      dup_count <= 2'h0;
    end else if (d2m_valid && d2m_kind == MSG_DUP_CHECK && dup_count != 2'h3) begin
      dup_count <= dup_count + 2'h1;
    end
  end

  // necessary condition only: timeout drops are not visible here
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      armed <= 1'b0;
    end else if (m2d_valid && m2d_kind == MSG_UNCONN_CLOSE) begin
      armed <= 1'b0;
    end else if (m2d_valid && m2d_kind == MSG_SET_TIMEOUT && m2d_data != 8'h00) begin
      armed <= 1'b1;
    end
  end

  poll_group_a: assert property (poll_rsp |-> d2m_group == 2'h1)
    else $error("poll response not in group 1");
  expl_group_a: assert property (rsp && !poll_rsp |-> d2m_group == 2'h2)
    else $error("explicit response not in group 2");
  poll_cause_a: assert property (poll_rsp |-> $past(m2d_valid) &&
    $past(m2d_kind) == MSG_POLL && $past(m2d_group) == 2'h2)
    else $error("poll response without poll command");
  expl_cause_a: assert property (d2m_valid && d2m_kind == MSG_EXPL_RSP
    |-> $past(m2d_valid) && $past(m2d_group) == 2'h2)
    else $error("explicit response without group 2 request");
  reply_src_a: assert property (rsp |-> d2m_src == $past(m2d_dest))
    else $error("reply source differs from request target");
  dup_first_a: assert property (rsp |-> dup_count == 2'h2)
    else $error("reply before two address checks");
  dup_gap_a: assert property (d2m_valid && d2m_kind == MSG_DUP_CHECK
    |=> (!(d2m_valid && d2m_kind == MSG_DUP_CHECK))[*8])
    else $error("address checks too close");
  armed_poll_a: assert property (poll_rsp |-> armed)
    else $error("poll answered before timeout armed");

  c_poll: cover property (poll_rsp);
  c_expl: cover property (d2m_valid && d2m_kind == MSG_EXPL_RSP);
  c_dup:  cover property (d2m_valid && d2m_kind == MSG_DUP_CHECK);
endmodule

// >>> tb/test_fieldbus_slave_node_config_status.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
`define WAITFOR(c, lim, nm) begin k = 0; while (!(c) && k < lim) begin \
  @(negedge i_clock); k++; end if (!(c)) begin miscompares++; \
  $display("CHECK FAILED %s exp 1 got 0", nm); complete_run(); end end
module test_fieldbus_slave_node_config_status
  import fbs_pkg::*;
;
  logic        i_clock = 0, i_rstn = 0, sw_a = 0, sw_b = 0;
  logic        alive = 0, alive_en = 1, start = 0, stop = 0, poll = 0;
  logic [5:0]  addr_sw = 0;
  logic [31:0] pos = 0, p;
  logic [7:0]  tmo = 8'h05;
  logic [3:0]  ctrl = 0, c;
  logic [5:0]  node_address;
  fbs_rate_t   bit_rate;
  logic        online, io_ready, control_valid, lamp_ok, lamp_run, lamp_err;
  logic        x_ok, x_run, x_err, ready, position_valid, got;
  logic [3:0]  control_bits;
  logic [31:0] position;
  int          miscompares = 0, n_checks = 0, k, i, prev, exp_ctl;
  int          n_sent = 0, base, flips;
  int          order[4] = '{3, 0, 1, 2};
  logic [31:0] exp_q[$];
  fbs_rate_t   rates[4] = '{RATE_125K, RATE_250K, RATE_500K, RATE_INVALID};

  fbs_link_if link_a();
  fbs_link_if link_b();

  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) alive <= alive_en && ($urandom % 8 == 0);
  always @(posedge i_clock) if (link_a.d2m_valid) n_sent <= n_sent + 1;

  fbs_slave_node #(.TICK_CYCLES(10)) fbs_slave_node_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address_switch(addr_sw),
    .i_rate_select_switch_a(sw_a), .i_rate_select_switch_b(sw_b),
    .i_position(pos), .i_ctrl_alive(alive), .link(link_a.dev),
    .o_node_address(node_address), .o_bit_rate(bit_rate),
    .o_online(online), .o_io_ready(io_ready), .o_control_bits(control_bits),
    .o_control_valid(control_valid), .o_lamp_ok(lamp_ok),
    .o_lamp_run(lamp_run), .o_lamp_err(lamp_err));
  // second node faces the bench, which misbehaves as master on purpose
  fbs_slave_node #(.TICK_CYCLES(10)) fbs_slave_node_x_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address_switch(addr_sw),
    .i_rate_select_switch_a(sw_a), .i_rate_select_switch_b(sw_b),
    .i_position(pos), .i_ctrl_alive(alive), .link(link_b.dev),
    .o_node_address(), .o_bit_rate(), .o_online(), .o_io_ready(),
    .o_control_bits(), .o_control_valid(), .o_lamp_ok(x_ok),
    .o_lamp_run(x_run), .o_lamp_err(x_err));
  fbs_master fbs_master_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_node_address(addr_sw),
    .i_start(start), .i_stop(stop), .i_timeout_ms(tmo), .i_poll(poll),
    .i_control(ctrl), .link(link_a.mst), .o_ready(ready),
    .o_position(position), .o_position_valid(position_valid));
  fbs_link_checker fbs_link_checker_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .m2d_valid(link_a.m2d_valid),
    .m2d_group(link_a.m2d_group), .m2d_kind(link_a.m2d_kind),
    .m2d_dest(link_a.m2d_dest), .m2d_data(link_a.m2d_data),
    .d2m_valid(link_a.d2m_valid), .d2m_group(link_a.d2m_group),
    .d2m_kind(link_a.d2m_kind), .d2m_src(link_a.d2m_src),
    .d2m_data(link_a.d2m_data));

  initial begin
    link_b.m2d_valid = 1'b0;
    link_b.m2d_group = 2'h2;
    link_b.m2d_kind = MSG_NONE;
    link_b.m2d_dest = 6'h00;
    link_b.m2d_data = 8'h00;
  end

  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset(input int r);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    sw_a <= r[0];
    sw_b <= r[1];
    repeat (4) @(posedge i_clock);
    i_rstn <= 1'b1;
  endtask

  task automatic send2(input logic [1:0] g, input fbs_msg_t kd,
                       output logic rx);
    @(posedge i_clock);
    link_b.m2d_valid <= 1'b1;
    link_b.m2d_group <= g;
    link_b.m2d_kind <= kd;
    link_b.m2d_dest <= addr_sw;
    @(posedge i_clock);
    link_b.m2d_valid <= 1'b0;
    link_b.m2d_dest <= ~addr_sw;
    @(negedge i_clock);
    rx = link_b.d2m_valid;
  endtask

  // lamp flashing only shows as level changes over a long window
  task automatic count_flips(input bit run_lamp, output int f);
    logic last;
    f = 0;
    last = run_lamp ? lamp_run : lamp_err;
    repeat (11000) begin
      @(negedge i_clock);
      if ((run_lamp ? lamp_run : lamp_err) !== last) f++;
      last = run_lamp ? lamp_run : lamp_err;
    end
  endtask

  initial begin
    void'($urandom(56));
    addr_sw = 6'($urandom);
    tmo = 8'(5 + $urandom % 4);
    foreach (order[j]) begin
      do_reset(order[j]);
      base = n_sent;
      repeat (3) @(negedge i_clock);
      `CHK("rate", rates[order[j]], bit_rate)
      `CHK("lamps offline", 3'h0, {lamp_ok, lamp_run, lamp_err})
      if (order[j] == 3) begin
        repeat (400) @(negedge i_clock);
        `CHK("bad rate online", 1'b0, online)
        `CHK("bad rate sends", base, n_sent)
      end
    end
    `WAITFOR(online, 1000, "online")
    `CHK("address checks", base + 2, n_sent)
    `CHK("node address", addr_sw, node_address)
    count_flips(1'b0, flips);
    `CHK("err flashing", 1'b1, flips > 0)
    @(posedge i_clock);
    start <= 1'b1;
    @(posedge i_clock);
    start <= 1'b0;
    `WAITFOR(ready, 200, "ready")
    repeat (2) @(negedge i_clock);
    `CHK("io ready", 1'b1, io_ready)
    `CHK("lamps allocated", 3'b110, {lamp_ok, lamp_run, lamp_err})
    prev = 0;
    for (i = 0; i < 8; i++) begin
      c = (i < 2) ? 4'hF : 4'($urandom);
      exp_ctl = c & ~prev;
      prev = exp_ctl;
      p = $urandom;
      exp_q.push_back(p);
      @(posedge i_clock);
      pos <= p;
      ctrl <= c;
      poll <= 1'b1;
      @(posedge i_clock);
      poll <= 1'b0;
      `WAITFOR(control_valid, 10, "control valid")
      `CHK("control", exp_ctl, control_bits)
      `WAITFOR(position_valid, 10, "position valid")
      `CHK("position", exp_q[0], position)
      void'(exp_q.pop_front());
    end
    `WAITFOR(!io_ready, 300, "io drop")
    count_flips(1'b1, flips);
    `CHK("run flashing", 1'b1, flips > 0)
    `CHK("io stays down", 1'b0, io_ready)
    send2(2'h1, MSG_UNCONN_OPEN_EXPL, got);
    `CHK("group 1 open", 1'b0, got)
    send2(2'h2, MSG_UNCONN_OPEN_EXPL, got);
    `CHK("group 2 open", 1'b1, got)
    `CHK("open group", 2'h2, link_b.d2m_group)
    `CHK("config", {8'h00, 2'h2, addr_sw}, link_b.d2m_data[15:0])
    send2(2'h2, MSG_UNCONN_OPEN_IO, got);
    `CHK("open io", 1'b1, got)
    send2(2'h2, MSG_POLL, got);
    `CHK("poll unarmed", 1'b0, got)
    send2(2'h2, MSG_EXPL_READ, got);
    `CHK("explicit read", 1'b1, got)
    send2(2'h2, MSG_UNCONN_CLOSE, got);
    `CHK("close", 1'b1, got)
    send2(2'h2, MSG_EXPL_READ, got);
    `CHK("read closed", 1'b0, got)
    send2(2'h2, MSG_DUP_CHECK, got);
    `WAITFOR(x_err, 10, "duplicate fault")
    `CHK("dup lamps", 3'b001, {x_ok, x_run, x_err})
    @(posedge i_clock);
    alive_en <= 1'b0;
    `WAITFOR(!online, 1200, "watchdog")
    repeat (2) @(negedge i_clock);
    `CHK("stalled", 1'b0, online)
    alive_en <= 1'b1;
    repeat (50) @(negedge i_clock);
    `CHK("fault lamps", 3'b001, {lamp_ok, lamp_run, lamp_err})
    complete_run();
  end
endmodule
